/* File: sdi_ctrl_consts.vh */
// Purpose: constants for the sdi output source control block
// Assumes: 250 MHz system clock, 32-bit classic wishbone register bus
// Notes: definitions only
`ifndef SDI_CTRL_CONSTS_VH
`define SDI_CTRL_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_MAP 8'h04
`define REG_FMT 8'h08
`define REG_STATUS 8'h0c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_SRC_BIT 0
`define CTRL_LOCK_BIT 1
`define CTRL_OVL_BIT 2
`define CTRL_REF_BIT 3
`define CTRL_GPI_BIT 4
`define CTRL_GPO_LSB 6
`define CTRL_LINK_BIT 8
`define CTRL_RESET 9'h000
`define GPO_DISABLED 2'h0
`define GPO_ON_PRESENT 2'h1
`define GPO_ON_ABSENT 2'h2

// ----------------------------------------
// insertion map and format fields
// ----------------------------------------
`define MAP_B_LSB 4
`define MAP_RESET 7'h00
`define CODE_NONE 3'h0
`define CODE_MAX 3'h4
`define FMT_RESET 4'h0
`define FMT_1080_BIT 3
`define AUD_THRESH 16'h0147

// ----------------------------------------
// output sources
// ----------------------------------------
`define SRC_PASS 2'h0
`define SRC_GRAY 2'h1
`define SRC_IMAGE 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ 250000
`define GRAY_TIME_MS 7000
`define LEARN_TIME_MS 5000
`define WALK_STEP_MS 250
`define VERSION_TIME_MS 2000
`define DATA_PULSE_MS 50
`define FRONT_LEDS 12

`endif

/* File: sdi_ctrl_sva.sv */
// Purpose: port checker for sdi_output_source_control
// Assumes: all byte lanes written together
// Notes: control register shadowed from bus writes
`timescale 1ns/10ps
module sdi_ctrl_sva #(
  parameter [31:0] GRAY_CYCLES = 20
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire [1:0] out_source_o,
  input wire src_optical_o,
  input wire optical_tx_en_o,
  input wire overlay_on_o,
  input wire gpo_o,
  input wire [11:0] led_front_o,
  input wire led_coax_o,
  input wire led_optical_o
);
  localparam int GRAY_MAX = GRAY_CYCLES + 5;
  reg [7:0] ctrl;
  reg [5:0] age;
  wire boot_ok = age > 6'h28;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 8'h00;
      age <= 6'h00;
    end else begin
      if (age != 6'h3f) age <= age + 6'h01;
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i && wb_sel_i[0] &&
          wb_adr_i == 8'h00) ctrl <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // properties
  // ----
  sequence pass_seen;
    out_source_o == 2'h0;
  endsequence
  sequence pass_left;
    pass_seen ##1 out_source_o != 2'h0;
  endsequence
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  loss_gray_a: assert property (pass_left |-> ctrl[3] || out_source_o == 2'h1)
    else $error("input loss skipped gray");
  gray_bound_a: assert property (boot_ok && out_source_o == 2'h1 |->
    ##[1:GRAY_MAX] out_source_o != 2'h1) else $error("gray too long");
  overlay_img_a: assert property (overlay_on_o |-> out_source_o == 2'h2)
    else $error("overlay off image");
  ref_gen_a: assert property (ctrl[3] && $past(ctrl[3], 3) |-> out_source_o != 2'h0)
    else $error("pass in reference mode");
  tx_on_a: assert property (boot_ok |-> optical_tx_en_o) else $error("tx off");
  coax_led_a: assert property (src_optical_o && $past(src_optical_o, 2) |-> !led_coax_o)
    else $error("coax led unselected");
  opt_led_a: assert property (!src_optical_o && !$past(src_optical_o, 2) |-> !led_optical_o)
    else $error("optical led unselected");
  gpo_off_a: assert property (boot_ok && !(^ctrl[7:6]) && ctrl == $past(ctrl, 2) |-> !gpo_o)
    else $error("gpo not low");
  gpo_present_a: assert property (boot_ok && ctrl[7:6] == 2'h1 && ctrl == $past(ctrl, 2) |->
    gpo_o == led_front_o[2]) else $error("gpo not present flag");
  gpo_absent_a: assert property (boot_ok && ctrl[7:6] == 2'h2 && ctrl == $past(ctrl, 2) |->
    gpo_o != led_front_o[2]) else $error("gpo not absent flag");
endmodule // sdi_ctrl_sva

/* File: sdi_output_source_control.v */
// Purpose: source selection, generator policy, insertion map, gpi/gpo and indicators
// Assumes: valid flags and gpi arrive asynchronously; format, audio peaks and
//   remote bus hits come from logic on clk_i
// Notes: registers on classic wishbone, one wait state per access
`timescale 1ns/10ps
`include "sdi_ctrl_consts.vh"

// Behaviour
// - one selected input, coaxial or optical
// - format policy follows input or stays locked
// - learn format after five seconds valid input
// - overlay setting enables or disables moving box
// - overlay only drawn on stored image
// - pass-through routes valid input to outputs
// - reference-only always sends generated image
// - two codes map audio pairs to groups
// - both codes none means no insertion
// - gpi low inhibits insertion when configured
// - all-none map ignores the gpi
// - gpo high while input present
// - gpo high while input absent
// - power-up without input: gray, then image
// - input loss: gray seven seconds, then image
// - image size follows stored format
// - optical output always active, same signal
// - input led shows selected input valid
// - coax board led when selected and valid
// - optical board led when selected and valid
// - data led blinks on addressed bus traffic
// - audio led lit when present and inserted
// - present means above minus forty dbfs
// - power-up led walk, version, power on
// - status led once controller link established
module sdi_output_source_control #(
  parameter [31:0] GRAY_CYCLES = `GRAY_TIME_MS * `CLK_KHZ,
  parameter [31:0] LEARN_CYCLES = `LEARN_TIME_MS * `CLK_KHZ,
  parameter [31:0] WALK_CYCLES = `WALK_STEP_MS * `CLK_KHZ,
  parameter [31:0] VERSION_CYCLES = `VERSION_TIME_MS * `CLK_KHZ,
  parameter [31:0] PULSE_CYCLES = `DATA_PULSE_MS * `CLK_KHZ,
  parameter [11:0] FW_VERSION = 12'h5a3 // arbitrary version pattern
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire coax_valid_i,
  input wire optical_valid_i,
  input wire gpi_i,
  input wire [3:0] fmt_in_i,
  input wire fmt_ok_i,
  input wire [127:0] audio_peak_i,
  input wire bus_hit_i,
  output reg src_optical_o,
  output reg [1:0] out_source_o,
  output reg optical_tx_en_o,
  output reg overlay_on_o,
  output reg image_1080_o,
  output reg [3:0] stored_fmt_o,
  output reg [2:0] insert_a_o,
  output reg [2:0] insert_b_o,
  output reg gpo_o,
  output reg [11:0] led_front_o,
  output reg led_status_o,
  output reg led_coax_o,
  output reg led_optical_o
);

  localparam [1:0] S_BOOT = 2'h0;
  localparam [1:0] S_PASS = 2'h1;
  localparam [1:0] S_GRAY = 2'h2;
  localparam [1:0] S_IMAGE = 2'h3;

  reg [8:0] ctrl;
  reg [6:0] map;
  reg [3:0] stored_fmt;
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  reg [2:0] stable;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] gray_cnt;
  reg [31:0] learn_cnt;
  reg [3:0] learn_fmt;
  reg [31:0] boot_cnt;
  reg [3:0] boot_step;
  reg boot_done;
  reg [31:0] pulse_cnt;
  reg [1:0] pulse_phase;
  reg [7:0] aud_present;
  wire in_valid;
  wire pass_ok;
  wire inhibit;
  wire [2:0] code_a;
  wire [2:0] code_b;
  wire [2:0] eff_a;
  wire [2:0] eff_b;
  wire wb_req;
  wire [31:0] status_word;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // ack is registered: one wait state, and a held strobe is not taken again in its ack cycle
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // status: audio presence, input format, gpio state, boot and source
  assign status_word = {8'h00, aud_present, 4'h0, fmt_in_i, 1'b0, gpo_o, inhibit,
    stable[2], boot_done, out_source_o, in_valid};

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {23'h000000, ctrl};
          `REG_MAP: wb_dat_o <= {25'h0000000, map};
          `REG_FMT: wb_dat_o <= {28'h0000000, stored_fmt};
          `REG_STATUS: wb_dat_o <= status_word;
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
      map <= `MAP_RESET;
    end else if (ce_i && wb_req && wb_we_i) begin
      if (wb_adr_i == `REG_CTRL && wb_sel_i[0])
        ctrl[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == `REG_CTRL && wb_sel_i[1])
        ctrl[8] <= wb_dat_i[8];
      if (wb_adr_i == `REG_MAP && wb_sel_i[0])
        map <= wb_dat_i[6:0];
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // a level is accepted once the second and third stages agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      // gpi stages start at the idle high level so reset brings no false inhibit
      sync1 <= 3'h4;
      sync2 <= 3'h4;
      sync3 <= 3'h4;
      stable <= 3'h4;
    end else if (ce_i) begin
      sync1 <= {gpi_i, optical_valid_i, coax_valid_i};
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & stable);
    end
  end

  assign in_valid = ctrl[`CTRL_SRC_BIT] ? stable[1] : stable[0];
  assign pass_ok = in_valid & ~ctrl[`CTRL_REF_BIT];

  // ----------------------------------------
  // output source sequencing
  // ----------------------------------------
  // losing the input in pass shows gray before the stored image, unless reference mode is set, which goes straight to image
  always @* begin
    next_state = state;
    case (state)
      S_BOOT: begin
        if (boot_done)
          next_state = pass_ok ? S_PASS : S_GRAY;
      end
      S_PASS: begin
        if (ctrl[`CTRL_REF_BIT])
          next_state = S_IMAGE;
        else if (!in_valid)
          next_state = S_GRAY;
      end
      S_GRAY: begin
        if (pass_ok)
          next_state = S_PASS;
        else if (gray_cnt >= GRAY_CYCLES - 32'h1)
          next_state = S_IMAGE;
      end
      S_IMAGE: begin
        if (pass_ok)
          next_state = S_PASS;
      end
      default: next_state = S_BOOT;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_BOOT;
      gray_cnt <= 32'h0;
    end else if (ce_i) begin
      state <= next_state;
      if (state == S_GRAY && next_state == S_GRAY)
        gray_cnt <= gray_cnt + 32'h1;
      else
        gray_cnt <= 32'h0;
    end
  end

  // ----------------------------------------
  // format learning
  // ----------------------------------------
  // the learn window restarts whenever the input or its format changes
  always @(posedge clk_i) begin
    if (rst_i) begin
      stored_fmt <= `FMT_RESET;
      learn_cnt <= 32'h0;
      learn_fmt <= `FMT_RESET;
    end else if (ce_i) begin
      // a software write of the stored format wins over a learn in the same cycle
      learn_fmt <= fmt_in_i;
      if (wb_req && wb_we_i && wb_adr_i == `REG_FMT && wb_sel_i[0])
        stored_fmt <= wb_dat_i[3:0];
      else if (learn_cnt >= LEARN_CYCLES - 32'h1)
        stored_fmt <= learn_fmt;
      if (ctrl[`CTRL_LOCK_BIT] || !in_valid || !fmt_ok_i || fmt_in_i != learn_fmt)
        learn_cnt <= 32'h0;
      else if (learn_cnt < LEARN_CYCLES - 32'h1)
        learn_cnt <= learn_cnt + 32'h1;
      else
        learn_cnt <= learn_cnt;
    end
  end

  // ----------------------------------------
  // audio insertion
  // ----------------------------------------
  // codes above the last group count as no insertion
  assign code_a = (map[2:0] > `CODE_MAX) ? `CODE_NONE : map[2:0];
  assign code_b = (map[6:4] > `CODE_MAX) ? `CODE_NONE : map[6:4];
  assign inhibit = ctrl[`CTRL_GPI_BIT] & ~stable[2];
  assign eff_a = inhibit ? `CODE_NONE : code_a;
  assign eff_b = inhibit ? `CODE_NONE : code_b;

  // one presence flag per audio channel: above the threshold means signal
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_aud
      always @(posedge clk_i) begin
        if (rst_i)
          aud_present[ch] <= 1'b0;
        else if (ce_i)
          aud_present[ch] <= audio_peak_i[ch*16 +: 16] > `AUD_THRESH;
      end
    end
  endgenerate

  // ----------------------------------------
  // power-up indicator sequence
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      boot_cnt <= 32'h0;
      boot_step <= 4'h0;
      boot_done <= 1'b0;
    end else if (ce_i && !boot_done) begin
      // walk the lamps, then hold the version; boot_done then freezes the count
      if (boot_step < `FRONT_LEDS) begin
        if (boot_cnt >= WALK_CYCLES - 32'h1) begin
          boot_cnt <= 32'h0;
          boot_step <= boot_step + 4'h1;
        end else begin
          boot_cnt <= boot_cnt + 32'h1;
        end
      end else if (boot_cnt >= VERSION_CYCLES - 32'h1) begin
        boot_done <= 1'b1;
      end else begin
        boot_cnt <= boot_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // data activity blink
  // ----------------------------------------
  // phase 1 lit, phase 2 dark; hits during a blink are absorbed
  always @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt <= 32'h0;
      pulse_phase <= 2'h0;
    end else if (ce_i) begin
      // idle: the counter stays clear until the next hit
      if (pulse_phase == 2'h0) begin
        pulse_cnt <= 32'h0;
        if (bus_hit_i)
          pulse_phase <= 2'h1;
      end else if (pulse_cnt >= PULSE_CYCLES - 32'h1) begin
        pulse_cnt <= 32'h0;
        pulse_phase <= (pulse_phase == 2'h1) ? 2'h2 : 2'h0;
      end else begin
        pulse_cnt <= pulse_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_optical_o <= 1'b0;
      out_source_o <= `SRC_GRAY;
      optical_tx_en_o <= 1'b0;
      overlay_on_o <= 1'b0;
      image_1080_o <= 1'b0;
      stored_fmt_o <= `FMT_RESET;
      insert_a_o <= `CODE_NONE;
      insert_b_o <= `CODE_NONE;
      gpo_o <= 1'b0;
      led_front_o <= 12'h000;
      led_status_o <= 1'b0;
      led_coax_o <= 1'b0;
      led_optical_o <= 1'b0;
    end else if (ce_i) begin
      src_optical_o <= ctrl[`CTRL_SRC_BIT];
      case (state)
        S_PASS: out_source_o <= `SRC_PASS;
        S_IMAGE: out_source_o <= `SRC_IMAGE;
        default: out_source_o <= `SRC_GRAY;
      endcase
      optical_tx_en_o <= 1'b1;
      overlay_on_o <= ctrl[`CTRL_OVL_BIT] && state == S_IMAGE;
      image_1080_o <= stored_fmt[`FMT_1080_BIT];
      stored_fmt_o <= stored_fmt;
      insert_a_o <= eff_a;
      insert_b_o <= eff_b;
      case (ctrl[`CTRL_GPO_LSB +: 2])
        `GPO_ON_PRESENT: gpo_o <= in_valid;
        `GPO_ON_ABSENT: gpo_o <= ~in_valid;
        default: gpo_o <= 1'b0;
      endcase
      if (!boot_done) begin
        if (boot_step < `FRONT_LEDS)
          led_front_o <= 12'h001 << boot_step;
        else
          led_front_o <= FW_VERSION;
      end else begin
        led_front_o[0] <= 1'b1;
        led_front_o[1] <= 1'b0;
        led_front_o[2] <= in_valid;
        led_front_o[3] <= pulse_phase == 2'h1;
        led_front_o[7:4] <= aud_present[3:0] & {4{eff_a != `CODE_NONE}};
        led_front_o[11:8] <= aud_present[7:4] & {4{eff_b != `CODE_NONE}};
      end
      // board lamps follow the per-input flags, gated by the selection
      led_status_o <= ctrl[`CTRL_LINK_BIT];
      led_coax_o <= ~ctrl[`CTRL_SRC_BIT] & stable[0];
      led_optical_o <= ctrl[`CTRL_SRC_BIT] & stable[1];
    end
  end

endmodule // sdi_output_source_control

/* File: sdi_output_source_control_tb.sv */
// Purpose: self-checking bench for sdi_output_source_control
// Assumes: shortened timer parameters
// Notes: read data scored through a queue by a monitor
`timescale 1ns/10ps
`include "sdi_ctrl_consts.vh"
module sdi_output_source_control_tb;
  logic clk_i = 1'b0;
  logic rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, coax_valid_i, optical_valid_i, gpi_i;
  logic fmt_ok_i, bus_hit_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, fmt_in_i, f;
  logic [31:0] wb_dat_i, e, m;
  logic [31:0] r0, r1;
  logic [7:0] aud_exp;
  logic [127:0] audio_peak_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, src_optical_o, optical_tx_en_o, overlay_on_o, image_1080_o, gpo_o;
  wire led_status_o, led_coax_o, led_optical_o, dark;
  wire [1:0] out_source_o;
  wire [3:0] stored_fmt_o;
  wire [2:0] insert_a_o, insert_b_o;
  wire [11:0] led_front_o, width;
  logic [31:0] exp_q[$], msk_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int i;
  always #2 clk_i = ~clk_i;
  sdi_output_source_control #(.GRAY_CYCLES(20), .LEARN_CYCLES(16), .WALK_CYCLES(2),
    .VERSION_CYCLES(4), .PULSE_CYCLES(3)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coax_valid_i(coax_valid_i),
    .optical_valid_i(optical_valid_i), .gpi_i(gpi_i), .fmt_in_i(fmt_in_i),
    .fmt_ok_i(fmt_ok_i), .audio_peak_i(audio_peak_i), .bus_hit_i(bus_hit_i),
    .src_optical_o(src_optical_o), .out_source_o(out_source_o),
    .optical_tx_en_o(optical_tx_en_o), .overlay_on_o(overlay_on_o),
    .image_1080_o(image_1080_o), .stored_fmt_o(stored_fmt_o), .insert_a_o(insert_a_o),
    .insert_b_o(insert_b_o), .gpo_o(gpo_o), .led_front_o(led_front_o),
    .led_status_o(led_status_o), .led_coax_o(led_coax_o), .led_optical_o(led_optical_o));
  video_sink_model u_sink (.clk_i(clk_i), .src_i(out_source_o), .tx_en_i(optical_tx_en_o),
    .hd_i(image_1080_o), .width_o(width), .dark_o(dark));
  // ----
  // tasks
  // ----
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, ex, mk);
    int n;
    n = 0;
    if (!we) begin
      exp_q.push_back(ex);
      msk_q.push_back(mk);
    end
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) n_mismatch++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp("read data", e & m, wb_dat_o & m);
    end
  end
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish();
  end
  // ----
  // tests
  // ----
  initial begin
    {rst_i, ce_i, gpi_i, wb_sel_i} = 7'h7f;
    {wb_cyc_i, wb_stb_i, wb_we_i, coax_valid_i, optical_valid_i, fmt_ok_i, bus_hit_i} = 7'h00;
    {wb_adr_i, wb_dat_i, fmt_in_i, audio_peak_i} = 172'h0;
    i = $urandom(647);
    wt(10);
    rst_i <= 1'b0;
    wt(32);
    cmp("front leds", 1, led_front_o);
    cmp("tx enable", 1, optical_tx_en_o);
    cmp("dark", 0, dark);
    wt(22);
    cmp("source", 2, out_source_o);
    cmp("width", 32'h500, width);
    $display("boot test done");
    wb(1, 8'h10, 32'hffffffff, 0, 0);
    wb(0, 8'h10, 0, 0, 32'hffffffff);
    wb(1, 8'h00, 32'h144, 0, 0);
    wb(0, 8'h00, 0, 32'h144, 32'h1ff);
    cmp("status led", 1, led_status_o);
    for (i = 0; i < 5; i++) begin
      wb(1, 8'h04, (i << 4) | (4 - i), 0, 0);
      wt(2);
      cmp("group a", 4 - i, insert_a_o);
      cmp("group b", i, insert_b_o);
    end
    wb(0, 8'h04, 0, 32'h40, 32'h7f);
    wb(1, 8'h04, 0, 0, 0);
    wt(2);
    cmp("groups none", 0, {insert_a_o, insert_b_o});
    wb(1, 8'h00, 32'h154, 0, 0);
    wb(1, 8'h04, 32'h12, 0, 0);
    gpi_i <= 1'b0;
    wt(8);
    cmp("inhibited", 0, insert_a_o);
    gpi_i <= 1'b1;
    r0 = $urandom & 32'h03ff03ff;
    r1 = $urandom;
    aud_exp = {(r1[31:16] > `AUD_THRESH), (r1[15:0] > `AUD_THRESH),
      (r0[31:16] > `AUD_THRESH), (r0[15:0] > `AUD_THRESH), 4'h1};
    audio_peak_i <= {r1, r0, 32'h0, 16'h0147, 16'h0148};
    wt(8);
    cmp("group a", 2, insert_a_o);
    cmp("audio leds", aud_exp, led_front_o[11:4]);
    bus_hit_i <= 1'b1;
    wt(1);
    bus_hit_i <= 1'b0;
    wt(3);
    cmp("data led", 1, led_front_o[3]);
    wt(8);
    cmp("data led", 0, led_front_o[3]);
    $display("setting test done");
    coax_valid_i <= 1'b1;
    wt(8);
    cmp("source", 0, out_source_o);
    cmp("coax led", 1, led_coax_o);
    cmp("input led", 1, led_front_o[2]);
    cmp("gpo", 1, gpo_o);
    cmp("overlay", 0, overlay_on_o);
    wb(1, 8'h00, 32'h155, 0, 0);
    wt(8);
    cmp("coax led", 0, led_coax_o);
    cmp("source select", 1, src_optical_o);
    cmp("source", 1, out_source_o);
    cmp("gpo", 0, gpo_o);
    optical_valid_i <= 1'b1;
    wt(8);
    cmp("optical led", 1, led_optical_o);
    cmp("source", 0, out_source_o);
    wb(1, 8'h00, 32'h08d, 0, 0);
    wt(8);
    cmp("reference", 1, out_source_o != 2'h0);
    cmp("gpo", 0, gpo_o);
    optical_valid_i <= 1'b0;
    wt(8);
    cmp("gpo", 1, gpo_o);
    wt(25);
    cmp("source", 2, out_source_o);
    cmp("overlay", 1, overlay_on_o);
    wb(1, 8'h00, 32'h089, 0, 0);
    wt(4);
    cmp("overlay", 0, overlay_on_o);
    wb(1, 8'h00, 32'h001, 0, 0);
    wt(4);
    cmp("gpo", 0, gpo_o);
    ce_i <= 1'b0;
    optical_valid_i <= 1'b1;
    wt(8);
    cmp("frozen source", 2, out_source_o);
    ce_i <= 1'b1;
    wt(8);
    cmp("source", 0, out_source_o);
    $display("source test done");
    f = {1'b1, 3'($urandom)};
    fmt_in_i <= f;
    fmt_ok_i <= 1'b1;
    coax_valid_i <= 1'b1;
    wb(1, 8'h00, 32'h0, 0, 0);
    wt(30);
    cmp("stored format", f, stored_fmt_o);
    wb(1, 8'h00, 32'h002, 0, 0);
    fmt_in_i <= ~f;
    wt(30);
    cmp("stored format", f, stored_fmt_o);
    wb(0, 8'h08, 0, f, 32'hf);
    coax_valid_i <= 1'b0;
    wt(35);
    cmp("image 1080", 1, image_1080_o);
    cmp("width", 32'h780, width);
    $display("format test done");
    tally_and_finish();
  end
endmodule // sdi_output_source_control_tb
bind sdi_output_source_control sdi_ctrl_sva #(.GRAY_CYCLES(GRAY_CYCLES)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .out_source_o(out_source_o), .src_optical_o(src_optical_o),
  .optical_tx_en_o(optical_tx_en_o), .overlay_on_o(overlay_on_o), .gpo_o(gpo_o),
  .led_front_o(led_front_o), .led_coax_o(led_coax_o), .led_optical_o(led_optical_o));

/* File: video_sink_model.sv */
// Purpose: downstream receiver model for the sdi output
// Assumes: one line width per generated format
// Notes: width 0 means the input signal is passed through
`timescale 1ns/10ps
`include "sdi_ctrl_consts.vh"
module video_sink_model (
  input wire clk_i,
  input wire [1:0] src_i,
  input wire tx_en_i,
  input wire hd_i,
  output logic [11:0] width_o,
  output logic dark_o
);
  // ----
  // line width seen by the receiver
  // ----
  always @(posedge clk_i) begin
    dark_o <= !tx_en_i;
    width_o <= (src_i == `SRC_PASS) ? 12'h000 : (hd_i ? 12'h780 : 12'h500);
  end
endmodule // video_sink_model
